// *** pkg/afe_pkg.sv ***
// constants shared by the converter back end and its output formatter
package afe_pkg;

  // range placement codes
  localparam logic [1:0] PLACE_TOP    = 2'h2;
  localparam logic [1:0] PLACE_BOTTOM = 2'h3;

  // output format codes
  localparam logic [1:0] FMT_UPPER_ONLY = 2'h1;
  localparam logic [1:0] FMT_NIBBLE     = 2'h3;

  // phase counts less one per format
  localparam logic [1:0] LAST_BYTES  = 2'h1;
  localparam logic [1:0] LAST_UPPER  = 2'h0;
  localparam logic [1:0] LAST_NIBBLE = 2'h3;

  // code range
  localparam longint CODE_FS  = 64'sd65535;
  localparam longint CODE_MID = 64'sd32767;
  localparam longint CODE_MIN = 64'sd0;
  localparam logic [15:0] CODE_ALL_ONES = 16'hffff;

  // offset stage: span in microvolts, centre held doubled (127.5 * 2)
  localparam longint OFF_SPAN_UV   = 64'sd260000;
  localparam longint OFF_CENTRE_X2 = 64'sd255;
  localparam longint OFF_STEP_X2   = 64'sd2;

  // gain stage, scaled by 100: 0.66 + code * 7.34 / 511
  localparam longint GAIN_BASE_X100  = 64'sd66;
  localparam longint GAIN_SLOPE_X100 = 64'sd734;
  localparam longint GAIN_DEN        = 64'sd511;
  localparam longint GAIN_SCALE      = 64'sd100;

  // converter full scale in microvolts
  localparam longint VFS_NORMAL_UV  = 64'sd2000000;
  localparam longint VFS_REDUCED_UV = 64'sd1200000;

  // block power-down bit positions
  localparam int PD_ADC     = 0;
  localparam int PD_REF_DAC = 1;
  localparam int PD_CHAN0   = 2;
  localparam int NUM_CHAN   = 3;
  localparam int CHAN_BLUE  = 2;

  localparam logic [1:0] CHAN_SEL_INVALID = 2'h3;

endpackage

// *** core/afe_fmt.sv ***
// output formatter: presents a 16-bit code as bytes, upper byte or nibbles
`timescale 1ns/10ps
`default_nettype none
module afe_fmt (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        load_i,
  input  wire logic [15:0] code_i,
  input  wire logic [1:0]  fmt_i,
  input  wire logic        compat_i,
  output logic      [7:0]  pix_o,
  output logic      [1:0]  phase_o,
  output logic             valid_o
);

  typedef enum logic [0:0] {
    FMT_IDLE = 1'b0,
    FMT_SEND = 1'b1
  } afe_fmt_state_type;

  typedef struct packed {
    afe_fmt_state_type st;
    logic [15:0]       data;
    logic              nibble;
    logic [1:0]        idx;
    logic [1:0]        last;
    logic [7:0]        pix;
    logic [1:0]        phase;
    logic              valid;
  } afe_fmt_reg_type;

  afe_fmt_reg_type r;
  afe_fmt_reg_type next_r;

  function automatic logic is_nibble(input logic [1:0] f, input logic c);
    is_nibble = (f == afe_pkg::FMT_NIBBLE) && c;
  endfunction

  // slice of the code shown in phase i
  function automatic logic [7:0] slice(input logic [15:0] d, input logic nib,
                                       input logic [1:0] i);
    slice = 8'h00;
    if (nib) begin
      unique case (i)
        2'h0: slice = {d[15:12], 4'h0};
        2'h1: slice = {d[11:8], 4'h0};
        2'h2: slice = {d[7:4], 4'h0};
        2'h3: slice = {d[3:0], 4'h0};
      endcase
    end else begin
      slice = i[0] ? d[7:0] : d[15:8];
    end
  endfunction

  // ------------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    if (load_i) begin
      next_r.data   = code_i;
      next_r.nibble = is_nibble(fmt_i, compat_i);
      if (is_nibble(fmt_i, compat_i)) begin
        next_r.last = afe_pkg::LAST_NIBBLE;
      end else if (fmt_i == afe_pkg::FMT_UPPER_ONLY) begin
        next_r.last = afe_pkg::LAST_UPPER;
      end else begin
        next_r.last = afe_pkg::LAST_BYTES;
      end
      next_r.pix   = slice(code_i, is_nibble(fmt_i, compat_i), 2'h0);
      next_r.phase = 2'h0;
      next_r.valid = 1'b1;
      next_r.idx   = 2'h1;
      next_r.st    = (next_r.last == 2'h0) ? FMT_IDLE : FMT_SEND;
    end else if (r.st == FMT_SEND) begin
      next_r.pix   = slice(r.data, r.nibble, r.idx);
      next_r.phase = r.idx;
      next_r.valid = 1'b1;
      next_r.idx   = r.idx + 2'h1;
      if (r.idx == r.last) begin
        next_r.st = FMT_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '{st: FMT_IDLE, data: 16'h0000, nibble: 1'b0, idx: 2'h0, last: 2'h0,
             pix: 8'h00, phase: 2'h0, valid: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign pix_o   = r.pix;
  assign phase_o = r.phase;
  assign valid_o = r.valid;

  a_nibble_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    valid_o && r.nibble |-> pix_o[3:0] == 4'h0)
    else $error("nibble phase drove low pins");

  a_byte_order: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    load_i && !is_nibble(fmt_i, compat_i) && fmt_i != afe_pkg::FMT_UPPER_ONLY ##1 !load_i
    |-> pix_o == $past(code_i[15:8]) && phase_o == 2'h0 ##1
        valid_o && phase_o == 2'h1 && pix_o == $past(code_i[7:0], 2))
    else $error("byte pair order wrong");

  a_upper_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    load_i && fmt_i == afe_pkg::FMT_UPPER_ONLY ##1 !load_i |-> valid_o ##1 !valid_o)
    else $error("upper byte format sent more than one phase");

  a_nibble_count: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    load_i && is_nibble(fmt_i, compat_i) ##1 !load_i [*4]
    |-> $past(valid_o, 1) && phase_o == 2'h3 ##1 !valid_o)
    else $error("nibble format did not send four phases");

endmodule // afe_fmt
`default_nettype wire

// *** core/afe_core.sv ***
// converter back end: referencing, offset, gain, placement, invert, power
// ------------------------------------------------------------------
// How it works
// - placement 10: zero input gives all-ones code.
// - placement 11: zero input gives all-zero code.
// - placement 00 or 01: zero input gives mid code 7fff.
// - raw code is scaled voltage times 65535 plus placement base.
// - invert set: output 65535 minus raw, else raw.
// - format field picks two bytes, upper byte only, or four nibbles when compat timing mode is set.
// - double sampling subtracts reset level, otherwise reference level (pin or DAC, below).
// - reference DAC powered down uses pin voltage, else DAC code level.
// - offset code centred at 127.5, spanning plus or minus 260 mV.
// - gain is 0.66 plus code times 7.34 over 511.
// - device enabled by default; global enable low powers all down.
// - separate power-down bits for internal blocks.
// - single or dual channel mode disables unused channels.
// ------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module afe_core #(
  parameter longint RLC_STEP_UV = 64'sd100000,
  parameter longint RLC_BOT_UV  = 64'sd0,
  parameter int     PD_WIDTH    = 8
) (
  input  wire logic                CLK_SYS_I,
  input  wire logic                ARST_N_I,
  input  wire logic                SAMPLE_I,
  input  wire logic signed [23:0]  VIDEO_UV_I,
  input  wire logic signed [23:0]  RESET_LVL_UV_I,
  input  wire logic signed [23:0]  REFERENCE_BIAS_PIN_UV_I,
  input  wire logic                CDS_EN_I,
  input  wire logic                REF_DAC_POWERDOWN_I,
  input  wire logic        [3:0]   REF_DAC_CODE_I,
  input  wire logic        [7:0]   OFFSET_CODE_I,
  input  wire logic        [8:0]   GAIN_CODE_I,
  input  wire logic        [1:0]   RANGE_PLACEMENT_SEL_I,
  input  wire logic                REDUCED_FULLSCALE_SEL_I,
  input  wire logic                OUTPUT_INVERT_I,
  input  wire logic        [1:0]   OUTPUT_FORMAT_SEL_I,
  input  wire logic                COMPAT_TIMING_MODE_I,
  input  wire logic                GLOBAL_EN_I,
  input  wire logic [PD_WIDTH-1:0] BLOCK_PD_I,
  input  wire logic                SINGLE_CHANNEL_MODE_I,
  input  wire logic                DUAL_CHANNEL_MODE_I,
  input  wire logic        [1:0]   CHAN_SEL_I,
  output logic             [15:0]  CODE_O,
  output logic                     CODE_VALID_O,
  output logic             [7:0]   PIXEL_OUT_BUS_O,
  output logic             [1:0]   PIXEL_PHASE_O,
  output logic                     PIXEL_VALID_O,
  output logic             [2:0]   CHAN_EN_O,
  output logic [PD_WIDTH-1:0]      BLOCK_EN_O,
  output logic                     POWERED_O
);

  typedef struct packed {
    logic [15:0]         code;
    logic                code_valid;
    logic [2:0]          chan_en;
    logic [PD_WIDTH-1:0] block_en;
    logic                powered;
  } afe_core_reg_type;

  afe_core_reg_type r;
  afe_core_reg_type next_r;

  // ------------------------------------------------------------------
  // analogue signal path, worked in microvolts
  // ------------------------------------------------------------------
  logic signed [63:0] vref;
  logic signed [63:0] v1;
  logic signed [63:0] off;
  logic signed [63:0] v2;
  logic signed [63:0] gnum;
  logic signed [63:0] vfs;
  logic signed [63:0] scaled;
  logic signed [63:0] base;
  logic signed [63:0] raw_s;
  logic        [15:0] raw;
  logic        [15:0] out_code;
  logic               adc_on;

  always_comb begin
    if (REF_DAC_POWERDOWN_I) begin
      vref = 64'(REFERENCE_BIAS_PIN_UV_I);
    end else begin
      vref = RLC_BOT_UV + RLC_STEP_UV * $signed({60'h0, REF_DAC_CODE_I});
    end
    v1 = CDS_EN_I ? 64'(VIDEO_UV_I) - 64'(RESET_LVL_UV_I)
                  : 64'(VIDEO_UV_I) - vref;
    off = (afe_pkg::OFF_SPAN_UV * ($signed({56'h0, OFFSET_CODE_I}) * afe_pkg::OFF_STEP_X2
          - afe_pkg::OFF_CENTRE_X2)) / afe_pkg::OFF_CENTRE_X2;
    v2 = v1 + off;
    gnum = afe_pkg::GAIN_BASE_X100 * afe_pkg::GAIN_DEN
         + $signed({55'h0, GAIN_CODE_I}) * afe_pkg::GAIN_SLOPE_X100;
    vfs = REDUCED_FULLSCALE_SEL_I ? afe_pkg::VFS_REDUCED_UV : afe_pkg::VFS_NORMAL_UV;
    scaled = (v2 * gnum * afe_pkg::CODE_FS)
           / (afe_pkg::GAIN_DEN * afe_pkg::GAIN_SCALE * vfs);
    unique case (RANGE_PLACEMENT_SEL_I)
      afe_pkg::PLACE_TOP:    base = afe_pkg::CODE_FS;
      afe_pkg::PLACE_BOTTOM: base = afe_pkg::CODE_MIN;
      default:               base = afe_pkg::CODE_MID;
    endcase
    raw_s = scaled + base;
    if (raw_s < afe_pkg::CODE_MIN) begin
      raw = 16'h0000;
    end else if (raw_s > afe_pkg::CODE_FS) begin
      raw = afe_pkg::CODE_ALL_ONES;
    end else begin
      raw = raw_s[15:0];
    end
    out_code = OUTPUT_INVERT_I ? afe_pkg::CODE_ALL_ONES - raw : raw;
  end

  // ------------------------------------------------------------------
  // power and channel enables
  // ------------------------------------------------------------------
  assign adc_on = GLOBAL_EN_I && !BLOCK_PD_I[afe_pkg::PD_ADC];

  always_comb begin
    next_r = r;
    next_r.powered    = GLOBAL_EN_I;
    next_r.code_valid = 1'b0;
    for (int i = 0; i < PD_WIDTH; i++) begin
      next_r.block_en[i] = GLOBAL_EN_I && !BLOCK_PD_I[i];
    end
    for (int c = 0; c < afe_pkg::NUM_CHAN; c++) begin
      next_r.chan_en[c] = GLOBAL_EN_I && !BLOCK_PD_I[afe_pkg::PD_CHAN0 + c];
      if (SINGLE_CHANNEL_MODE_I) begin
        if (DUAL_CHANNEL_MODE_I || CHAN_SEL_I == afe_pkg::CHAN_SEL_INVALID
            || CHAN_SEL_I != 2'(c)) begin
          next_r.chan_en[c] = 1'b0;
        end
      end else if (DUAL_CHANNEL_MODE_I && c == afe_pkg::CHAN_BLUE) begin
        next_r.chan_en[c] = 1'b0;
      end
    end
    if (SAMPLE_I && adc_on) begin
      next_r.code       = out_code;
      next_r.code_valid = 1'b1;
    end
  end

  // reset state is fully enabled so the part comes up working
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      r <= '{code: 16'h0000, code_valid: 1'b0, chan_en: 3'h7,
             block_en: {PD_WIDTH{1'b1}}, powered: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  assign CODE_O       = r.code;
  assign CODE_VALID_O = r.code_valid;
  assign CHAN_EN_O    = r.chan_en;
  assign BLOCK_EN_O   = r.block_en;
  assign POWERED_O    = r.powered;

  // ------------------------------------------------------------------
  // output presentation
  // ------------------------------------------------------------------
  afe_fmt u_fmt (
    .clk_i    (CLK_SYS_I),
    .arst_n_i (ARST_N_I),
    .load_i   (r.code_valid),
    .code_i   (r.code),
    .fmt_i    (OUTPUT_FORMAT_SEL_I),
    .compat_i (COMPAT_TIMING_MODE_I),
    .pix_o    (PIXEL_OUT_BUS_O),
    .phase_o  (PIXEL_PHASE_O),
    .valid_o  (PIXEL_VALID_O)
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_top_black: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    SAMPLE_I && adc_on && v2 == 64'sd0 && !OUTPUT_INVERT_I
    && RANGE_PLACEMENT_SEL_I == afe_pkg::PLACE_TOP |=> CODE_O == 16'hffff)
    else $error("top placement black level not all ones");

  a_bottom_black: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    SAMPLE_I && adc_on && v2 == 64'sd0 && !OUTPUT_INVERT_I
    && RANGE_PLACEMENT_SEL_I == afe_pkg::PLACE_BOTTOM |=> CODE_O == 16'h0000)
    else $error("bottom placement black level not zero");

  a_mid_black: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    SAMPLE_I && adc_on && v2 == 64'sd0 && !OUTPUT_INVERT_I
    && !RANGE_PLACEMENT_SEL_I[1] |=> CODE_O == 16'h7fff)
    else $error("bipolar black level not mid code");

  a_saturate_low: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    SAMPLE_I && adc_on && scaled < 64'sd0 && !OUTPUT_INVERT_I
    && RANGE_PLACEMENT_SEL_I == afe_pkg::PLACE_BOTTOM |=> CODE_O == 16'h0000)
    else $error("negative code wrapped");

  a_invert_pair: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    CODE_VALID_O |-> CODE_O == ($past(OUTPUT_INVERT_I) ? 16'hffff - $past(raw) : $past(raw)))
    else $error("invert stage gave wrong code");

  a_off_quiet: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    !GLOBAL_EN_I |=> !CODE_VALID_O && CHAN_EN_O == 3'h0 && !POWERED_O ##1 !PIXEL_VALID_O)
    else $error("powered down part still active");

  a_dual_blue: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    DUAL_CHANNEL_MODE_I |=> !CHAN_EN_O[2])
    else $error("unused channel left enabled in dual mode");

  a_single_one: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    SINGLE_CHANNEL_MODE_I |=> $countones(CHAN_EN_O) <= 1)
    else $error("more than one channel enabled in single mode");

  a_adc_pd: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    BLOCK_PD_I[afe_pkg::PD_ADC] |=> !CODE_VALID_O && !BLOCK_EN_O[afe_pkg::PD_ADC])
    else $error("converter ran while powered down");

endmodule // afe_core
`default_nettype wire

// *** bench/afe_cap.sv ***
// receiving controller model: rebuilds each code from the pixel bus phases
`timescale 1ns/10ps
`default_nettype none
module afe_cap (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        valid_i,
  input  wire logic [1:0]  phase_i,
  input  wire logic [7:0]  pix_i,
  input  wire logic [1:0]  fmt_i,
  input  wire logic        compat_i,
  output logic      [15:0] word_o,
  output logic             done_o
);
  logic       nib;
  logic [1:0] last;

  assign nib  = (fmt_i == 2'h3) && compat_i;
  assign last = (fmt_i == 2'h1) ? 2'h0 : (nib ? 2'h3 : 2'h1);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_o <= 16'h0000;
      done_o <= 1'b0;
    end else begin
      done_o <= valid_i && (phase_i == last);
      if (valid_i && nib) begin
        word_o <= {(phase_i == 2'h0) ? 12'h000 : word_o[11:0], pix_i[7:4]};
      end else if (valid_i) begin
        word_o <= {(phase_i == 2'h0) ? 8'h00 : word_o[7:0], pix_i};
      end
    end
  end
endmodule // afe_cap
`default_nettype wire

// *** bench/tb_adc_code_format_output.sv ***
// testbench for the converter back end and its output bus
`timescale 1ns/10ps
`default_nettype none
module tb_adc_code_format_output;
  typedef struct packed {
    logic signed [23:0] v, rs, rb;
    logic cds, pd;
    logic [3:0] dac;
    logic [7:0] off;
    logic [8:0] gain;
    logic [1:0] place;
    logic red, inv;
    logic [1:0] fmt;
    logic compat;
  } afe_row_type;

  logic        clk_sys, arst_n, sample, glob, single, dual, code_v, done, pix_v, pwr;
  logic [7:0]  bpd, pix, ben;
  logic [1:0]  sel, ph;
  logic [2:0]  cen;
  logic [15:0] code, word, e;
  afe_row_type cur;
  afe_row_type rows [10];
  int          n_fail = 0, cmp_count = 0, cyc = 0, n_valid = 0, k;

  afe_core u_afe_core (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .SAMPLE_I(sample),
    .VIDEO_UV_I(cur.v), .RESET_LVL_UV_I(cur.rs), .REFERENCE_BIAS_PIN_UV_I(cur.rb),
    .CDS_EN_I(cur.cds), .REF_DAC_POWERDOWN_I(cur.pd), .REF_DAC_CODE_I(cur.dac),
    .OFFSET_CODE_I(cur.off), .GAIN_CODE_I(cur.gain), .RANGE_PLACEMENT_SEL_I(cur.place),
    .REDUCED_FULLSCALE_SEL_I(cur.red), .OUTPUT_INVERT_I(cur.inv),
    .OUTPUT_FORMAT_SEL_I(cur.fmt), .COMPAT_TIMING_MODE_I(cur.compat), .GLOBAL_EN_I(glob),
    .BLOCK_PD_I(bpd), .SINGLE_CHANNEL_MODE_I(single), .DUAL_CHANNEL_MODE_I(dual),
    .CHAN_SEL_I(sel), .CODE_O(code), .CODE_VALID_O(code_v), .PIXEL_OUT_BUS_O(pix),
    .PIXEL_PHASE_O(ph), .PIXEL_VALID_O(pix_v), .CHAN_EN_O(cen), .BLOCK_EN_O(ben),
    .POWERED_O(pwr));

  afe_cap u_afe_cap (.clk_i(clk_sys), .arst_n_i(arst_n), .valid_i(pix_v), .phase_i(ph),
    .pix_i(pix), .fmt_i(cur.fmt), .compat_i(cur.compat), .word_o(word), .done_o(done));

  // ------------------------------------------------------------------
  // clock, timeout and helpers
  // ------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (code_v === 1'b1) n_valid++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask

  // code worked out from the signal chain equations
  function automatic logic [15:0] exp_code(input afe_row_type r);
    longint rf, v2, raw;
    if (r.cds) rf = r.rs;
    else if (r.pd) rf = r.rb;
    else rf = 100000 * r.dac;
    v2 = r.v - rf + 260000 * (2 * longint'(r.off) - 255) / 255;
    raw = v2 * (33726 + 734 * longint'(r.gain)) * 65535;
    raw = raw / (64'sd51100 * (r.red ? 1200000 : 2000000));
    raw += (r.place == 2'h2) ? 65535 : ((r.place == 2'h3) ? 0 : 32767);
    if (raw > 65535) raw = 65535;
    if (raw < 0) raw = 0;
    return r.inv ? 16'(65535 - raw) : 16'(raw);
  endfunction

  task automatic wait_done();
    k = 0;
    while (done !== 1'b1 && k < 12) begin
      @(negedge clk_sys);
      k++;
    end
    check("done", {15'h0, done}, 16'h0001);
  endtask

  task automatic conv();
    sample = 1'b1;
    @(negedge clk_sys);
    sample = 1'b0;
    wait_done();
  endtask

  task automatic en_chk(input logic g, input logic [7:0] pd, input logic s, d,
                        input logic [1:0] sl, input logic [2:0] ce, input logic [7:0] be);
    glob = g;
    bpd = pd;
    single = s;
    dual = d;
    sel = sl;
    repeat (2) @(negedge clk_sys);
    check("enables", {4'h0, pwr, cen, ben}, {4'h0, g, ce, be});
  endtask

  task automatic refused_chk();
    k = n_valid;
    sample = 1'b1;
    @(negedge clk_sys);
    sample = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("ignored sample", 16'(n_valid - k), 16'h0000);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rows = '{
      '{24'hfffc05, '0, 24'h0927c0, '1, '0, '0, 8'h80, '0, 2'h0, '0, '0, 2'h0, '0},
      '{24'hfffc05, '0, 24'h0927c0, '1, '0, '0, 8'h80, '0, 2'h1, '0, '0, 2'h2, '0},
      '{24'hfffc05, '0, 24'h0927c0, '1, '0, '0, 8'h80, '0, 2'h2, '0, '0, 2'h1, '0},
      '{24'hfffc05, '0, 24'h0927c0, '1, '0, '0, 8'h80, '0, 2'h3, '0, '0, 2'h0, '0},
      '{24'hfffc05, '0, 24'h0927c0, '1, '0, '0, 8'h80, '0, 2'h2, '0, '1, 2'h0, '0},
      '{24'h0927c0, 24'h7a1200, 24'h0186a0, '0, '1, '0, 8'hc8, 9'h12c, 2'h0, '0, '0, 2'h3, '1},
      '{24'h0aae60, '0, 24'h7a1200, '0, '0, 4'h5, 8'h32, 9'h064, 2'h3, '1, '1, 2'h3, '0},
      '{24'h7a1200, '0, '0, '1, '0, '0, 8'h80, 9'h1ff, 2'h2, '0, '0, 2'h0, '0},
      '{24'h85ee00, '0, '0, '1, '0, '0, 8'h80, 9'h1ff, 2'h3, '0, '0, 2'h1, '0},
      '{24'h030d40, 24'hfb6c20, '0, '1, '0, '0, 8'h00, 9'h1ff, 2'h0, '1, '0, 2'h2, '0}};
    cur = rows[0];
    {sample, single, dual, sel, bpd, arst_n} = '0;
    glob = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("reset state", {4'h0, pwr, cen, ben}, 16'h0fff);
    check("reset code", code, 16'h0000);
    arst_n = 1'b1;
    @(negedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      // controller order: gain, then offset, then reference code with the rest
      cur.gain = rows[i].gain;
      @(negedge clk_sys);
      cur.off = rows[i].off;
      @(negedge clk_sys);
      cur = rows[i];
      e = exp_code(rows[i]);
      conv();
      check("code", code, e);
      check("bus word", word, (cur.fmt == 2'h1) ? {8'h00, e[15:8]} : e);
    end
    // back-to-back conversions: the second restarts the bus sequence
    cur = rows[0];
    sample = 1'b1;
    @(negedge clk_sys);
    cur = rows[7];
    @(negedge clk_sys);
    sample = 1'b0;
    wait_done();
    check("restart word", word, exp_code(rows[7]));
    en_chk(1'b1, 8'h00, 1'b0, 1'b1, 2'h0, 3'h3, 8'hff);
    for (int s = 0; s < 4; s++) begin
      en_chk(1'b1, 8'h00, 1'b1, 1'b0, 2'(s), (s == 3) ? 3'h0 : 3'(1 << s), 8'hff);
    end
    en_chk(1'b1, 8'h00, 1'b1, 1'b1, 2'h1, 3'h0, 8'hff);
    en_chk(1'b1, 8'h0a, 1'b0, 1'b0, 2'h0, 3'h5, 8'hf5);
    en_chk(1'b1, 8'h01, 1'b0, 1'b0, 2'h0, 3'h7, 8'hfe);
    refused_chk();
    en_chk(1'b0, 8'h00, 1'b0, 1'b0, 2'h0, 3'h0, 8'h00);
    refused_chk();
    // second reset while powered down: part must come up enabled and working
    arst_n = 1'b0;
    @(negedge clk_sys);
    check("rerun reset", {4'h0, pwr, cen, ben}, 16'h0fff);
    check("rerun code", code, 16'h0000);
    glob = 1'b1;
    cur = rows[2];
    arst_n = 1'b1;
    @(negedge clk_sys);
    conv();
    check("code after reset", code, exp_code(rows[2]));
    check("word after reset", word, {8'h00, exp_code(rows[2]) >> 8});
    print_verdict();
  end
endmodule // tb_adc_code_format_output
`default_nettype wire
